// file: orpc_cfg.svh
`ifndef ORPC_CFG_SVH
`define ORPC_CFG_SVH

// =====================================
// clock and timing
`define ORPC_CLK_HZ 25000000
`define ORPC_CLR_PULSE_MS 20
`define ORPC_SCAN_US 1000
`define ORPC_CLR_CYCLES ((`ORPC_CLR_PULSE_MS * (`ORPC_CLK_HZ / 1000)) + (`ORPC_SCAN_US * (`ORPC_CLK_HZ / 1000000)))

// =====================================
// speed limits in Hz
`define ORPC_SPEED_MIN 17'h0000a
`define ORPC_SPEED_SHORT_MAX 17'h07fff
`define ORPC_SPEED_LONG_MAX 17'h186a0

// =====================================
// reset and home position values
`define ORPC_POS_RESET 32'h0000_0000
`define ORPC_POS_HOME 32'h0000_0000
`endif

// file: orpc_pkg.sv
`default_nettype none
package orpc_pkg;
    typedef enum logic [2:0] {
        ST_IDLE,
        ST_FAST,
        ST_CREEP,
        ST_FINISH,
        ST_COMPLETE,
        ST_ABORT
    } orpc_state_e;

    // speed operands
    typedef struct packed {
        logic long_form;
        logic [16:0] return_speed;
        logic [14:0] creep_speed;
    } orpc_speed_s;

    // current position, upper and lower word
    typedef struct packed {
        logic [15:0] high;
        logic [15:0] low;
    } orpc_pos_s;
endpackage
`default_nettype wire

// file: orpc_pulse_gen.sv
`timescale 1ns/10ps
`default_nettype none
`include "orpc_cfg.svh"
module orpc_pulse_gen
(
    // clock and reset
    input wire logic i_sys_clk,
    input wire logic i_reset,
    // control
    input wire logic i_enable,
    input wire logic [16:0] i_freq,
    // pulse train
    output logic o_pulse,
    output logic o_step
);
    localparam logic [25:0] CLK_HZ = 26'(`ORPC_CLK_HZ);

    logic [25:0] acc;
    logic [25:0] next_acc;
    logic next_pulse;
    logic next_step;
    logic [25:0] sum;

    // fractional divider: toggle twice per output period
    // clock divided by frequency
    always_comb
    begin
        sum = acc + {8'h00, i_freq, 1'b0};
        next_acc = acc;
        next_pulse = o_pulse;
        next_step = 1'b0;
        if (!i_enable)
        begin
            next_acc = 26'h0;
            next_pulse = 1'b0;
        end
        else if (sum >= CLK_HZ)
        begin
            next_acc = sum - CLK_HZ;
            next_pulse = ~o_pulse;
            next_step = ~o_pulse;
        end
        else
        begin
            next_acc = sum;
        end
    end

    always_ff @(posedge i_sys_clk or posedge i_reset)
    begin
        if (i_reset)
        begin
            acc <= 26'h0;
            o_pulse <= 1'b0;
            o_step <= 1'b0;
        end
        else
        begin
            acc <= next_acc;
            o_pulse <= next_pulse;
            o_step <= next_step;
        end
    end
endmodule // orpc_pulse_gen
`default_nettype wire

// file: orpc_clear_timer.sv
`timescale 1ns/10ps
`default_nettype none
module orpc_clear_timer
#(
    parameter int CYCLES = 525000
)
(
    // clock and reset
    input wire logic i_sys_clk,
    input wire logic i_reset,
    // trigger
    input wire logic i_start,
    // active level
    output logic o_active
);
    localparam logic [19:0] LAST = 20'(CYCLES - 1);

    logic [19:0] cnt;
    logic [19:0] next_cnt;
    logic next_active;

    // hold for the full clear time
    always_comb
    begin
        next_cnt = cnt;
        next_active = o_active;
        if (i_start)
        begin
            next_cnt = 20'h0;
            next_active = 1'b1;
        end
        else if (o_active)
        begin
            if (cnt == LAST)
            begin
                next_active = 1'b0;
            end
            else
            begin
                next_cnt = cnt + 20'h1;
            end
        end
    end

    always_ff @(posedge i_sys_clk or posedge i_reset)
    begin
        if (i_reset)
        begin
            cnt <= 20'h0;
            o_active <= 1'b0;
        end
        else
        begin
            cnt <= next_cnt;
            o_active <= next_active;
        end
    end
endmodule // orpc_clear_timer
`default_nettype wire

// file: orpc_top.sv
`timescale 1ns/10ps
`default_nettype none
`include "orpc_cfg.svh"
module orpc_top
#(
    parameter int CLR_CYCLES = `ORPC_CLR_CYCLES
)
(
    // clock and reset
    input wire logic i_sys_clk,
    input wire logic i_reset,
    // command and operands
    input wire logic i_home_return_cmd,
    input wire logic i_channel_sel,
    input wire orpc_pkg::orpc_speed_s i_speed,
    // home switch sources
    input wire logic i_home_switch,
    input wire logic i_home_switch_internal,
    input wire logic i_home_switch_select,
    // control flags
    input wire logic i_clear_output_enable,
    input wire logic i_ch0_immediate_stop,
    input wire logic i_ch1_immediate_stop,
    // pulse and clear outputs
    output logic o_pulse_out_ch0,
    output logic o_pulse_out_ch1,
    output logic o_clear_out_ch0,
    output logic o_clear_out_ch1,
    output logic o_dir_fwd,
    // status
    output logic o_instr_complete_flag,
    output logic o_ch0_busy_monitor,
    output logic o_ch1_busy_monitor,
    // current positions
    output logic [15:0] o_ch0_position_low,
    output logic [15:0] o_ch0_position_high,
    output logic [15:0] o_ch1_position_low,
    output logic [15:0] o_ch1_position_high
);
    // =====================================
    // helpers
    function automatic logic [16:0] clamp_speed(input logic [16:0] v, input logic [16:0] hi);
        logic [16:0] r;
        r = v;
        if (v < `ORPC_SPEED_MIN)
        begin
            r = `ORPC_SPEED_MIN;
        end
        else if (v > hi)
        begin
            r = hi;
        end
        return r;
    endfunction

    // =====================================
    // declarations
    orpc_pkg::orpc_state_e state;
    orpc_pkg::orpc_state_e next_state;
    logic chan;
    logic next_chan;
    logic cmd_prev;
    logic next_cmd_prev;
    logic sw_prev;
    logic next_sw_prev;
    logic complete;
    logic next_complete;
    logic clr_chan;
    logic next_clr_chan;
    logic [1:0] clear_out;
    logic [1:0] next_clear_out;
    logic [1:0] busy;
    logic [1:0] next_busy;
    logic clr_start;
    logic clr_active;
    logic gen_en;
    logic gen_pulse;
    logic gen_step;
    logic [16:0] gen_freq;
    logic [16:0] fast_freq;
    logic [16:0] creep_freq;
    logic sw_now;
    logic sw_rise;
    logic sw_fall;
    logic cmd_rise;
    logic stop_now;
    logic [1:0] stop_req;
    logic [1:0] pulse_out;
    orpc_pkg::orpc_pos_s pos [2];
    orpc_pkg::orpc_pos_s next_pos [2];

    // =====================================
    // operand conditioning
    // return speed limited by operand form
    assign fast_freq = clamp_speed(i_speed.return_speed,
        i_speed.long_form ? `ORPC_SPEED_LONG_MAX : `ORPC_SPEED_SHORT_MAX);
    assign creep_freq = clamp_speed({2'b00, i_speed.creep_speed}, `ORPC_SPEED_SHORT_MAX);

    assign sw_now = i_home_switch_select ? i_home_switch_internal : i_home_switch;
    assign sw_rise = sw_now & ~sw_prev;
    assign sw_fall = ~sw_now & sw_prev;
    assign cmd_rise = i_home_return_cmd & ~cmd_prev;

    assign stop_req = {i_ch1_immediate_stop, i_ch0_immediate_stop};
    assign stop_now = stop_req[chan];

    // =====================================
    // sequencer
    always_comb
    begin
        next_state = state;
        next_chan = chan;
        next_complete = complete;
        next_busy = busy;
        next_clr_chan = clr_chan;
        clr_start = 1'b0;
        gen_en = 1'b0;
        gen_freq = fast_freq;
        next_cmd_prev = i_home_return_cmd;
        next_sw_prev = sw_now;
        unique case (state)
            orpc_pkg::ST_IDLE:
            begin
                // start only while the channel is idle
                if (cmd_rise && !busy[i_channel_sel] && !stop_req[i_channel_sel])
                begin
                    next_chan = i_channel_sel;
                    next_complete = 1'b0;
                    next_busy[i_channel_sel] = 1'b1;
                    next_state = orpc_pkg::ST_FAST;
                end
            end
            orpc_pkg::ST_FAST:
            begin
                gen_en = 1'b1;
                gen_freq = fast_freq;
                // drop of command or stop halts at once
                if (!i_home_return_cmd || stop_now)
                begin
                    gen_en = 1'b0;
                    next_state = orpc_pkg::ST_ABORT;
                end
                else if (sw_rise)
                begin
                    gen_freq = creep_freq;
                    next_state = orpc_pkg::ST_CREEP;
                end
            end
            orpc_pkg::ST_CREEP:
            begin
                gen_en = 1'b1;
                gen_freq = creep_freq;
                // drop of command or stop halts at once
                if (!i_home_return_cmd || stop_now)
                begin
                    gen_en = 1'b0;
                    next_state = orpc_pkg::ST_ABORT;
                end
                else if (sw_fall)
                begin
                    gen_en = 1'b0;
                    next_state = orpc_pkg::ST_FINISH;
                end
            end
            orpc_pkg::ST_FINISH:
            begin
                // clear only when enabled on completion
                if (i_clear_output_enable)
                begin
                    clr_start = 1'b1;
                    next_clr_chan = chan;
                end
                next_complete = 1'b1;
                next_state = orpc_pkg::ST_COMPLETE;
            end
            orpc_pkg::ST_COMPLETE:
            begin
                next_busy[chan] = 1'b0;
                next_state = orpc_pkg::ST_IDLE;
            end
            orpc_pkg::ST_ABORT:
            begin
                // stopped without completion
                next_busy[chan] = 1'b0;
                next_state = orpc_pkg::ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge i_sys_clk or posedge i_reset)
    begin
        if (i_reset)
        begin
            state <= orpc_pkg::ST_IDLE;
            chan <= 1'b0;
            cmd_prev <= 1'b0;
            sw_prev <= 1'b0;
            complete <= 1'b0;
            busy <= 2'b00;
            clr_chan <= 1'b0;
        end
        else
        begin
            state <= next_state;
            chan <= next_chan;
            cmd_prev <= next_cmd_prev;
            sw_prev <= next_sw_prev;
            complete <= next_complete;
            busy <= next_busy;
            clr_chan <= next_clr_chan;
        end
    end

    // =====================================
    // pulse generation and clear pulse
    orpc_pulse_gen u_pulse_gen
    (
        .i_sys_clk(i_sys_clk),
        .i_reset(i_reset),
        .i_enable(gen_en),
        .i_freq(gen_freq),
        .o_pulse(gen_pulse),
        .o_step(gen_step)
    );

    orpc_clear_timer #(.CYCLES(CLR_CYCLES)) u_clear_timer
    (
        .i_sys_clk(i_sys_clk),
        .i_reset(i_reset),
        .i_start(clr_start),
        .o_active(clr_active)
    );

    // =====================================
    // output routing and position counters
    genvar g;
    generate
        for (g = 0; g < 2; g++)
        begin : g_chan
            // pulses only on the selected channel
            assign pulse_out[g] = gen_pulse & (chan == 1'(g)) & busy[g];
            assign next_clear_out[g] = clr_active & (clr_chan == 1'(g));

            always_comb
            begin
                next_pos[g] = pos[g];
                if (state == orpc_pkg::ST_FINISH && chan == 1'(g))
                begin
                    next_pos[g] = `ORPC_POS_HOME;
                end
                else if (gen_step && gen_en && chan == 1'(g))
                begin
                    next_pos[g] = pos[g] - 32'h0000_0001;
                end
            end

            always_ff @(posedge i_sys_clk or posedge i_reset)
            begin
                if (i_reset)
                begin
                    pos[g] <= `ORPC_POS_RESET;
                end
                else
                begin
                    pos[g] <= next_pos[g];
                end
            end
        end
    endgenerate

    always_ff @(posedge i_sys_clk or posedge i_reset)
    begin
        if (i_reset)
        begin
            clear_out <= 2'b00;
        end
        else
        begin
            clear_out <= next_clear_out;
        end
    end

    // =====================================
    // outputs
    assign o_pulse_out_ch0 = pulse_out[0];
    assign o_pulse_out_ch1 = pulse_out[1];
    assign o_clear_out_ch0 = clear_out[0];
    assign o_clear_out_ch1 = clear_out[1];
    assign o_dir_fwd = 1'b0;
    assign o_instr_complete_flag = complete;
    assign o_ch0_busy_monitor = busy[0];
    assign o_ch1_busy_monitor = busy[1];
    assign o_ch0_position_low = pos[0].low;
    assign o_ch0_position_high = pos[0].high;
    assign o_ch1_position_low = pos[1].low;
    assign o_ch1_position_high = pos[1].high;
endmodule // orpc_top
`default_nettype wire

// file: orpc_drive_model.sv
`timescale 1ns/10ps
`default_nettype none
module orpc_drive_model
#(
    parameter int FAST_N = 3,
    parameter int CREEP_N = 2
)
(
    // clock and arming
    input wire logic i_sys_clk,
    input wire logic i_arm,
    // pulse train seen by the drive
    input wire logic i_pulse,
    // home switch and pulse statistics
    output logic o_switch,
    output var int o_count,
    output var int o_period
);
    int now = 0;
    int stamp = 0;
    logic prev = 1'b0;
    initial o_switch = 1'b0;
    initial o_count = 0;
    initial o_period = 0;
    // =====================================
    // axis travel and switch
    // armed before switch, direct contact
    always @(posedge i_sys_clk)
    begin
        now <= now + 1;
        prev <= i_pulse;
        if (i_arm)
        begin
            o_count <= 0;
            o_switch <= 1'b0;
        end
        else if (i_pulse && !prev)
        begin
            o_count <= o_count + 1;
            o_period <= now - stamp;
            stamp <= now;
            o_switch <= (o_count + 1 >= FAST_N) && (o_count + 1 < FAST_N + CREEP_N);
        end
    end
endmodule // orpc_drive_model
`default_nettype wire

// file: orpc_top_sva.sv
`timescale 1ns/10ps
`default_nettype none
module orpc_top_sva
#(
    parameter int CLR_CYCLES = 20
)
(
    // clock and reset
    input wire logic i_sys_clk,
    input wire logic i_reset,
    // inputs
    input wire logic i_home_return_cmd,
    input wire logic i_channel_sel,
    input wire logic i_ch0_immediate_stop,
    // outputs
    input wire logic o_pulse_out_ch0,
    input wire logic o_pulse_out_ch1,
    input wire logic o_clear_out_ch0,
    input wire logic o_clear_out_ch1,
    input wire logic o_dir_fwd,
    input wire logic o_instr_complete_flag,
    input wire logic o_ch0_busy_monitor,
    input wire logic o_ch1_busy_monitor,
    input wire logic [15:0] o_ch0_position_low,
    input wire logic [15:0] o_ch0_position_high,
    input wire logic [15:0] o_ch1_position_low,
    input wire logic [15:0] o_ch1_position_high
);
    default clocking cb @(posedge i_sys_clk); endclocking
    default disable iff (i_reset);
    logic [31:0] pos0;
    logic [31:0] pos1;
    logic [31:0] clr_cnt;
    logic [31:0] next_clr_cnt;
    logic busy;
    assign pos0 = {o_ch0_position_high, o_ch0_position_low};
    assign pos1 = {o_ch1_position_high, o_ch1_position_low};
    assign busy = o_ch0_busy_monitor | o_ch1_busy_monitor;
    // =====================================
    // clear pulse length
    always_comb next_clr_cnt = (o_clear_out_ch0 | o_clear_out_ch1) ? clr_cnt + 32'h1 : 32'h0;
    always_ff @(posedge i_sys_clk or posedge i_reset)
        if (i_reset)
            clr_cnt <= 32'h0;
        else
            clr_cnt <= next_clr_cnt;
    // =====================================
    // properties
    property p_dir; o_dir_fwd == 1'b0; endproperty
    a_dir: assert property (p_dir) else $error("direction not reverse");
    property p_one; !(o_pulse_out_ch0 && o_pulse_out_ch1); endproperty
    a_one: assert property (p_one) else $error("pulses on both channels");
    property p_quiet; !o_ch0_busy_monitor |-> !o_pulse_out_ch0; endproperty
    a_quiet: assert property (p_quiet) else $error("pulse while not busy");
    property p_stop; o_ch0_busy_monitor && i_ch0_immediate_stop |=> !o_pulse_out_ch0; endproperty
    a_stop: assert property (p_stop) else $error("pulse after stop");
    property p_drop; o_ch1_busy_monitor && !i_home_return_cmd |=> !o_pulse_out_ch1; endproperty
    a_drop: assert property (p_drop) else $error("pulse after command drop");
    property p_step; !$stable(pos0) |-> pos0 == $past(pos0) - 32'h1 || pos0 == 32'h0; endproperty
    a_step: assert property (p_step) else $error("position step wrong");
    property p_start;
        $rose(i_home_return_cmd) && !busy && !i_channel_sel && !i_ch0_immediate_stop
            |=> o_ch0_busy_monitor && !o_instr_complete_flag;
    endproperty
    a_start: assert property (p_start) else $error("start not taken");
    property p_done; $rose(o_instr_complete_flag) |-> busy ##1 !busy; endproperty
    a_done: assert property (p_done) else $error("busy not dropped after done");
    property p_zero; $rose(o_instr_complete_flag) && o_ch1_busy_monitor |-> pos1 == 32'h0; endproperty
    a_zero: assert property (p_zero) else $error("position not zero at home");
    property p_clr0; $rose(o_clear_out_ch0) |-> o_instr_complete_flag && pos0 == 32'h0; endproperty
    a_clr0: assert property (p_clr0) else $error("clear 0 without completion");
    property p_clr1; $rose(o_clear_out_ch1) |-> o_instr_complete_flag && pos1 == 32'h0; endproperty
    a_clr1: assert property (p_clr1) else $error("clear 1 without completion");
    property p_len;
        $fell(o_clear_out_ch0 | o_clear_out_ch1) |-> clr_cnt + 1 >= CLR_CYCLES && clr_cnt <= CLR_CYCLES + 1;
    endproperty
    a_len: assert property (p_len) else $error("clear pulse length wrong");
    c_done: cover property ($rose(o_instr_complete_flag));
    c_clr1: cover property ($rose(o_clear_out_ch1));
    c_abort: cover property ($fell(o_ch0_busy_monitor) && !o_instr_complete_flag);
endmodule // orpc_top_sva
bind orpc_top orpc_top_sva #(.CLR_CYCLES(CLR_CYCLES)) i_orpc_top_sva (
    .i_sys_clk(i_sys_clk), .i_reset(i_reset), .i_home_return_cmd(i_home_return_cmd),
    .i_channel_sel(i_channel_sel), .i_ch0_immediate_stop(i_ch0_immediate_stop),
    .o_pulse_out_ch0(o_pulse_out_ch0), .o_pulse_out_ch1(o_pulse_out_ch1), .o_clear_out_ch0(o_clear_out_ch0),
    .o_clear_out_ch1(o_clear_out_ch1), .o_dir_fwd(o_dir_fwd), .o_instr_complete_flag(o_instr_complete_flag),
    .o_ch0_busy_monitor(o_ch0_busy_monitor), .o_ch1_busy_monitor(o_ch1_busy_monitor),
    .o_ch0_position_low(o_ch0_position_low), .o_ch0_position_high(o_ch0_position_high),
    .o_ch1_position_low(o_ch1_position_low), .o_ch1_position_high(o_ch1_position_high));
`default_nettype wire

// file: orpc_top_test.sv
`timescale 1ns/10ps
`default_nettype none
module orpc_top_test;
    localparam int CLR = 20;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic cmd = 1'b0;
    logic chan = 1'b0;
    logic use_int = 1'b0;
    logic clr_en = 1'b0;
    logic stop0 = 1'b0;
    logic stop1 = 1'b0;
    logic arm = 1'b1;
    orpc_pkg::orpc_speed_s speed = 33'h0;
    logic p0, p1, c0, c1, dir, done, b0, b1, sw;
    logic [31:0] pos0;
    logic [31:0] pos1;
    int cnt, per, f, c, k;
    int fail_count = 0;
    int checks_done = 0;
    initial
    begin
        forever #20 clk = ~clk;
    end
    orpc_top #(.CLR_CYCLES(CLR)) i_orpc_top (.i_sys_clk(clk), .i_reset(rst), .i_home_return_cmd(cmd),
        .i_channel_sel(chan), .i_speed(speed), .i_home_switch(use_int ? 1'b0 : sw),
        .i_home_switch_internal(use_int ? sw : 1'b0), .i_home_switch_select(use_int),
        .i_clear_output_enable(clr_en), .i_ch0_immediate_stop(stop0), .i_ch1_immediate_stop(stop1),
        .o_pulse_out_ch0(p0), .o_pulse_out_ch1(p1), .o_clear_out_ch0(c0), .o_clear_out_ch1(c1),
        .o_dir_fwd(dir), .o_instr_complete_flag(done), .o_ch0_busy_monitor(b0), .o_ch1_busy_monitor(b1),
        .o_ch0_position_low(pos0[15:0]), .o_ch0_position_high(pos0[31:16]),
        .o_ch1_position_low(pos1[15:0]), .o_ch1_position_high(pos1[31:16]));
    orpc_drive_model i_orpc_drive_model (.i_sys_clk(clk), .i_arm(arm), .i_pulse(p0 | p1), .o_switch(sw),
        .o_count(cnt), .o_period(per));
    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp)
        begin
            fail_count++;
            $display("unexpected %s: expected %h, seen %h", name, exp, seen);
        end
    endtask
    task automatic summarize();
        $display("checks %0d, mismatches %0d", checks_done, fail_count);
        if (fail_count == 0 && checks_done > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    task automatic step(input int n);
        repeat (n) @(posedge clk);
        #2;
    endtask
    task automatic wait_for(input int n);
        int t;
        t = 0;
        while (cnt < n && t < 20000)
        begin
            step(1);
            t++;
        end
        check("pulse_wait", t < 20000, 1'b1);
    endtask
    function automatic logic near(input int seen, input int hz);
        return seen >= 25000000 / hz - 3 && seen <= 25000000 / hz + 3;
    endfunction
    // =====================================
    // one homing run with a start from rest
    task automatic start(input logic ch);
        arm = 1'b1;
        chan = ch;
        step(1);
        arm = 1'b0;
        cmd = 1'b1;
    endtask
    task automatic home(input logic ch, input logic en, input int fast, input int creep);
        int t;
        clr_en = en;
        start(ch);
        step(2);
        check("busy", {b1, b0}, ch ? 2'b10 : 2'b01);
        check("done_low", done, 1'b0);
        wait_for(3);
        check("fast_period", near(per, fast), 1'b1);
        step(4);
        check("pos_fast", ch ? pos1 : pos0, 32'hffff_fffd);
        wait_for(5);
        check("creep_period", near(per, creep), 1'b1);
        t = 0;
        while (done !== 1'b1 && t < 20000)
        begin
            step(1);
            t++;
        end
        check("pos_home", ch ? pos1 : pos0, 32'h0);
        step(4);
        check("busy_end", {b1, b0}, 2'b00);
        check("clear", {c1, c0}, en ? (ch ? 2'b10 : 2'b01) : 2'b00);
        cmd = 1'b0;
        step(CLR + 4);
        check("clear_end", {c1, c0}, 2'b00);
    endtask
    initial
    begin
        void'($urandom(17115));
        repeat (8) @(posedge clk);
        #2;
        rst = 1'b0;
        step(2);
        check("dir", dir, 1'b0);
        speed = {1'b0, 17'h186a0, 15'h7fff};
        home(1'b0, 1'b1, 32767, 32767);
        for (int r = 0; r < 4; r++)
        begin
            f = 20000 + $urandom % 80001;
            c = 20000 + $urandom % 12768;
            speed = {1'b1, 17'(f), 15'(c)};
            use_int = (r == 2);
            home(r[0], r[1], f, c);
        end
        start(1'b0);
        wait_for(2);
        stop0 = 1'b1;
        step(3);
        check("stop_busy", b0, 1'b0);
        check("stop_done", done, 1'b0);
        check("stop_pos", pos0, 32'(-cnt));
        cmd = 1'b0;
        step(1);
        cmd = 1'b1;
        step(3);
        check("stop_refuse", b0, 1'b0);
        stop0 = 1'b0;
        cmd = 1'b0;
        step(1);
        start(1'b1);
        wait_for(1);
        cmd = 1'b0;
        step(1);
        cmd = 1'b1;
        step(3);
        check("drop_busy", b1, 1'b0);
        k = cnt;
        step(2000);
        check("drop_quiet", cnt, k);
        check("drop_pos", pos1, 32'(-k));
        summarize();
    end
    initial
    begin
        // span of about three times the expected run
        #2500000;
        fail_count++;
        summarize();
    end
endmodule // orpc_top_test
`default_nettype wire
